// ===== src/iobf_pkg.sv
// Functional notes
// - Commands and responses share one block layout on every link.
// - Byte zero holds total block length including itself and checksum.
// - Packet bytes sit at positions one through length minus three.
// - Checksum is CRC-16, polynomial 0x8005, over count and packet bytes.
// - CRC starts at zero per block and must equal transmitted checksum.
// - Checksum low byte goes first; high byte ends the block.
// - Length mismatch with command yields an error or drops surplus bytes.
// - After the last input byte the device is busy and ignores input.
// - Bad checksum yields a four-byte block with status 0xFF, no execution.
package iobf_pkg;
  localparam logic [15:0] IOBF_CRC_POLY  = 16'h8005;
  localparam logic [15:0] IOBF_CRC_INIT  = 16'h0000;
  localparam logic [7:0]  IOBF_MIN_COUNT = 8'h04;
  localparam logic [7:0]  IOBF_MAX_COUNT = 8'h54;
  localparam logic [7:0]  IOBF_ERR_COUNT = 8'h04;
  localparam logic [7:0]  IOBF_ST_CRC    = 8'hff;
  localparam logic [7:0]  IOBF_ST_PARSE  = 8'h03;
  localparam int          IOBF_CNT_W     = 7;

  typedef enum logic [2:0] {
    IOBF_RX, IOBF_BUSY, IOBF_TX_CNT, IOBF_TX_PKT, IOBF_TX_CLO, IOBF_TX_CHI
  } iobf_state_t;

  // Bitwise CRC update: each byte enters LSB first against the top register bit.
  function automatic logic [15:0] iobf_crc_byte(input logic [15:0] crc,
                                                input logic [7:0]  d);
    logic [15:0] c;
    c = crc;
    for (int i = 0; i < 8; i++) begin
      if (c[15] ^ d[i]) begin
        c = {c[14:0], 1'b0} ^ IOBF_CRC_POLY;
      end else begin
        c = {c[14:0], 1'b0};
      end
    end
    return c;
  endfunction
endpackage

// ===== src/iobf_framer.sv
module iobf_framer
  import iobf_pkg::*;
#(
  parameter int MAX_PKT = 81
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       rxValid,
  input  wire logic [7:0] rxData,
  input  wire logic       rxAbort,
  output logic            cmdValid,
  output logic [7:0]      cmdData,
  output logic            cmdLast,
  output logic            cmdStart,
  output logic            busy,
  output logic            crcError,
  input  wire logic       exeDone,
  input  wire logic       rspValid,
  input  wire logic [7:0] rspData,
  input  wire logic       rspLast,
  output logic            rspReady,
  input  wire logic       txReady,
  output logic            txValid,
  output logic [7:0]      txData,
  output logic            txLast
);
  // The largest block leaves room for 81 packet bytes beside count and checksum.
  if (MAX_PKT < 1 || MAX_PKT > 81) begin : gen_bad_max_pkt
    $error("MAX_PKT out of range");
  end

  iobf_state_t             state_reg;
  logic [IOBF_CNT_W-1:0]   rxIdx_reg;
  logic [IOBF_CNT_W-1:0]   rxCount_reg;
  logic [15:0]             crc_reg;
  logic [7:0]              crcLo_reg;
  logic                    errBlock_reg;
  logic [7:0]              pkt_reg [MAX_PKT];
  logic [IOBF_CNT_W-1:0]   pktLen_reg;
  logic [IOBF_CNT_W-1:0]   txIdx_reg;
  logic [15:0]             txCrc_reg;
  logic [7:0]              txByte;
  logic                    txFire;
  logic                    rxLastByte;

  assign txFire     = txValid && txReady;
  // Index zero is the count byte, which can never close a block.
  assign rxLastByte = rxValid && (state_reg == IOBF_RX) && rxIdx_reg != '0 &&
                      rxIdx_reg == rxCount_reg - 7'(1);

  // Receive side: count byte, packet bytes passed through, checksum checked.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxIdx_reg   <= '0;
      rxCount_reg <= '0;
      crc_reg     <= IOBF_CRC_INIT;
      crcLo_reg   <= '0;
      crcError    <= 1'b0;
      cmdValid    <= 1'b0;
      cmdData     <= '0;
      cmdLast     <= 1'b0;
      cmdStart    <= 1'b0;
    end else begin
      cmdValid <= 1'b0;
      cmdLast  <= 1'b0;
      cmdStart <= 1'b0;
      if (state_reg != IOBF_RX || rxAbort) begin
        rxIdx_reg <= '0;
        crc_reg   <= IOBF_CRC_INIT;
      end else if (rxValid) begin
        rxIdx_reg <= rxIdx_reg + 7'(1);
        if (rxIdx_reg == '0) begin
          rxCount_reg <= rxData[IOBF_CNT_W-1:0];
          crcError    <= 1'b0;
          crc_reg     <= iobf_crc_byte(IOBF_CRC_INIT, rxData);
        end else if (rxIdx_reg < rxCount_reg - 7'(2)) begin
          crc_reg  <= iobf_crc_byte(crc_reg, rxData);
          cmdValid <= 1'b1;
          cmdData  <= rxData;
          cmdLast  <= (rxIdx_reg == rxCount_reg - 7'(3));
        end else if (rxIdx_reg == rxCount_reg - 7'(2)) begin
          crcLo_reg <= rxData;
        end
        if (rxLastByte) begin
          crcError <= (crc_reg != {rxData, crcLo_reg});
          cmdStart <= (crc_reg == {rxData, crcLo_reg});
        end
      end
    end
  end

  // Sequencing: receive, busy while executing, then emit the response block.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg    <= IOBF_RX;
      errBlock_reg <= 1'b0;
      busy         <= 1'b0;
    end else begin
      unique case (state_reg)
        IOBF_RX: begin
          if (rxLastByte) begin
            busy         <= 1'b1;
            errBlock_reg <= (crc_reg != {rxData, crcLo_reg});
            state_reg    <= (crc_reg != {rxData, crcLo_reg}) ? IOBF_TX_CNT : IOBF_BUSY;
          end
        end
        IOBF_BUSY: if (exeDone) state_reg <= IOBF_TX_CNT;
        IOBF_TX_CNT: if (txFire) state_reg <= (pktLen_reg != '0) ? IOBF_TX_PKT : IOBF_TX_CLO;
        IOBF_TX_PKT: if (txFire && txIdx_reg == pktLen_reg - 7'(1)) state_reg <= IOBF_TX_CLO;
        IOBF_TX_CLO: if (txFire) state_reg <= IOBF_TX_CHI;
        IOBF_TX_CHI: begin
          if (txFire) begin
            state_reg <= IOBF_RX;
            busy      <= 1'b0;
          end
        end
        default: state_reg <= IOBF_RX;
      endcase
    end
  end

  // Response capture; a checksum failure replaces it with the 0xFF status.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pktLen_reg <= '0;
      rspReady   <= 1'b0;
    end else begin
      rspReady <= (state_reg == IOBF_BUSY);
      if (state_reg == IOBF_RX && rxLastByte) begin
        pktLen_reg <= '0;
        if (crc_reg != {rxData, crcLo_reg}) begin
          pktLen_reg <= 7'(1);
        end
      end else if (state_reg == IOBF_BUSY && rspReady && rspValid &&
                   pktLen_reg < 7'(MAX_PKT)) begin
        pktLen_reg <= pktLen_reg + 7'(1);
      end
    end
  end

  // The response store has no reset; pktLen_reg alone says which entries are live.
  always_ff @(posedge clk) begin
    if (state_reg == IOBF_RX && rxLastByte) begin
      pkt_reg[0] <= IOBF_ST_CRC;
    end else if (state_reg == IOBF_BUSY && rspReady && rspValid &&
                 pktLen_reg < 7'(MAX_PKT)) begin
      pkt_reg[pktLen_reg] <= rspData;
    end
  end

  // Transmit side builds count, packet and CRC low-then-high.
  always_comb begin
    unique case (state_reg)
      IOBF_TX_CNT: txByte = {1'b0, pktLen_reg} + 8'(3);
      IOBF_TX_PKT: txByte = pkt_reg[txIdx_reg];
      IOBF_TX_CLO: txByte = txCrc_reg[7:0];
      IOBF_TX_CHI: txByte = txCrc_reg[15:8];
      default:     txByte = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txIdx_reg <= '0;
      txCrc_reg <= IOBF_CRC_INIT;
      txValid   <= 1'b0;
      txData    <= '0;
      txLast    <= 1'b0;
    end else begin
      if (state_reg == IOBF_BUSY || state_reg == IOBF_RX) begin
        txIdx_reg <= '0;
        txCrc_reg <= IOBF_CRC_INIT;
        txValid   <= 1'b0;
        txLast    <= 1'b0;
      end else if (txFire) begin
        // One idle cycle per byte lets the next byte come from the state the fire leads to.
        txValid <= 1'b0;
        if (state_reg == IOBF_TX_PKT) txIdx_reg <= txIdx_reg + 7'(1);
        if (state_reg == IOBF_TX_CNT || state_reg == IOBF_TX_PKT) begin
          txCrc_reg <= iobf_crc_byte(txCrc_reg, txData);
        end
      end else if (!txValid) begin
        txValid <= 1'b1;
        txData  <= txByte;
        txLast  <= (state_reg == IOBF_TX_CHI);
      end
    end
  end

  // Checks on what the block itself drives.
  AST_BUSY_AFTER_LAST: assert property (@(posedge clk) disable iff (!rst_n)
    rxLastByte |=> busy)
    else $error("busy not raised after last byte");

  AST_CRC_FAIL_NO_EXEC: assert property (@(posedge clk) disable iff (!rst_n)
    crcError |-> !cmdStart)
    else $error("command started despite checksum failure");

  AST_CMD_LAST_IN_BYTE: assert property (@(posedge clk) disable iff (!rst_n)
    cmdLast |-> cmdValid)
    else $error("cmdLast raised without cmdValid");

  AST_NO_CMD_WHILE_BUSY: assert property (@(posedge clk) disable iff (!rst_n)
    busy |-> !cmdValid && !rxLastByte)
    else $error("input accepted while busy");

  AST_TX_HOLDS: assert property (@(posedge clk) disable iff (!rst_n)
    txValid && !txReady |=> txValid && $stable(txData) && $stable(txLast))
    else $error("transmit byte changed before it was taken");

  AST_TX_COUNT_LEGAL: assert property (@(posedge clk) disable iff (!rst_n)
    txValid && state_reg == IOBF_TX_CNT |->
      txData >= IOBF_MIN_COUNT && txData <= IOBF_MAX_COUNT)
    else $error("response count byte out of range");

  AST_CRC_FAIL_STATUS: assert property (@(posedge clk) disable iff (!rst_n)
    txValid && errBlock_reg && state_reg == IOBF_TX_PKT |-> txData == IOBF_ST_CRC)
    else $error("checksum failure reply does not carry the failure status");

  AST_RSP_ONLY_WHEN_BUSY: assert property (@(posedge clk) disable iff (!rst_n)
    rspReady |-> busy)
    else $error("response taken while not busy");
endmodule

// ===== dv/iobf_engine_model.sv
module iobf_engine_model (
  input  wire logic       clk,
  input  wire logic       cmdStart,
  input  wire logic       rspReady,
  input  wire logic [7:0] rLen,
  input  wire logic [7:0] lag,
  output logic            rspValid,
  output logic [7:0]      rspData,
  output logic            rspLast,
  output logic            exeDone
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {rspValid, rspData, rspLast, exeDone} = '0;
    forever begin
      @(posedge clk iff cmdStart);
      repeat (lag) @(posedge clk);
      for (int i = 0; i < rLen; i++) begin
        #1 rspValid = 1'b1;
        rspData = 8'ha0 + 8'(i);
        rspLast = (i == rLen - 1);
        @(posedge clk iff rspReady);
      end
      // Released data shows the inverse so a stale byte is never mistaken for a live one.
      #1 rspValid = 1'b0;
      rspData = ~rspData;
      exeDone = 1'b1;
      @(posedge clk);
      #1 exeDone = 1'b0;
    end
  end
endmodule

// ===== dv/tb_io_block_framer_crc16.sv
module tb_io_block_framer_crc16;
  timeunit 1ns;
  timeprecision 1ps;
  import iobf_pkg::*;
  logic       clk = 0, rst_n = 0, rxValid = 0, rxAbort = 0, txReady = 0;
  logic [7:0] rxData = '0, rLen = 8'h01, lag = '0;
  logic       cmdValid, cmdLast, cmdStart, busy, crcError, exeDone;
  logic       rspValid, rspLast, rspReady, txValid, txLast;
  logic [7:0] cmdData, rspData, txData;
  logic [8:0] cmdQ[$], txQ[$];
  int         n_fail = 0, n_compared = 0;
  always #5 clk = ~clk;
  iobf_framer u_dut (
    .clk      (clk),
    .rst_n    (rst_n),
    .rxValid  (rxValid),
    .rxData   (rxData),
    .rxAbort  (rxAbort),
    .cmdValid (cmdValid),
    .cmdData  (cmdData),
    .cmdLast  (cmdLast),
    .cmdStart (cmdStart),
    .busy     (busy),
    .crcError (crcError),
    .exeDone  (exeDone),
    .rspValid (rspValid),
    .rspData  (rspData),
    .rspLast  (rspLast),
    .rspReady (rspReady),
    .txReady  (txReady),
    .txValid  (txValid),
    .txData   (txData),
    .txLast   (txLast)
  );
  iobf_engine_model u_eng (
    .clk      (clk),
    .cmdStart (cmdStart),
    .rspReady (rspReady),
    .rLen     (rLen),
    .lag      (lag),
    .rspValid (rspValid),
    .rspData  (rspData),
    .rspLast  (rspLast),
    .exeDone  (exeDone)
  );
  task automatic cmp(input string what, input logic [8:0] exp, input logic [8:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [15:0] crc8(input logic [15:0] c, input logic [7:0] d);
    for (int i = 0; i < 8; i++) c = (c[15] ^ d[i]) ? {c[14:0], 1'b0} ^ 16'h8005 : {c[14:0], 1'b0};
    return c;
  endfunction
  task automatic give_verdict;
    $display("Compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Sends one block of count n; bad corrupts the low checksum byte.
  task automatic send(input int n, input bit bad);
    logic [7:0]  b[$];
    logic [15:0] c;
    c = '0;
    b.push_back(8'(n));
    for (int i = 1; i <= n - 3; i++) b.push_back(8'($urandom));
    foreach (b[i]) c = crc8(c, b[i]);
    b.push_back(c[7:0] ^ 8'(bad));
    b.push_back(c[15:8]);
    foreach (b[i]) begin
      @(negedge clk);
      rxValid = 1'b1;
      rxData = b[i];
      if (i > 0 && i < n - 2) cmdQ.push_back({i == n - 3, b[i]});
    end
    @(posedge clk);
    #1;
    cmp("busy", 1, busy);
    cmp("start", !bad, cmdStart);
    cmp("crcError", bad, crcError);
    // A byte offered while busy must be ignored, or it would open a new block.
    @(negedge clk);
    rxData = 8'($urandom);
    @(negedge clk);
    rxValid = 1'b0;
    b.delete();
    if (bad) b.push_back(8'hff);
    else begin
      for (int i = 0; i < rLen && i < IOBF_MAX_COUNT - 3; i++) begin
        b.push_back(8'ha0 + 8'(i));
      end
    end
    b.push_front(8'(b.size() + 3));
    c = '0;
    foreach (b[i]) c = crc8(c, b[i]);
    foreach (b[i]) txQ.push_back({1'b0, b[i]});
    txQ.push_back({1'b0, c[7:0]});
    txQ.push_back({1'b1, c[15:8]});
    for (int k = 0; k < 3000 && (busy !== 1'b0 || txQ.size() > 0); k++) @(posedge clk);
    if (busy !== 1'b0 || txQ.size() > 0) begin
      n_fail++;
      give_verdict();
    end
  endtask
  // A block cut by rxAbort must leave the receiver waiting for a fresh count byte.
  task automatic send_cut(input int n);
    @(negedge clk);
    rxValid = 1'b1;
    rxData = 8'(n);
    @(negedge clk);
    rxData = 8'($urandom);
    cmdQ.push_back({1'b0, rxData});
    @(negedge clk);
    rxValid = 1'b0;
    rxAbort = 1'b1;
    @(negedge clk);
    rxAbort = 1'b0;
  endtask
  always @(negedge clk) txReady = ($urandom % 4) != 0;
  always @(posedge clk) begin
    if (cmdValid === 1'b1) cmp("cmd", cmdQ.size() ? cmdQ.pop_front() : 'x, {cmdLast, cmdData});
    if (txValid === 1'b1 && txReady) cmp("tx", txQ.size() ? txQ.pop_front() : 'x, {txLast, txData});
  end
  initial begin
    void'($urandom(32'h2936));
    repeat (10) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    send(4, 1'b0);
    rLen = 8'd83;
    lag = 8'd20;
    send(84, 1'b0);
    send(10, 1'b1);
    send_cut(20);
    rLen = 8'd3;
    lag = 8'd0;
    send(5 + $urandom % 40, 1'b0);
    give_verdict();
  end
endmodule
